// ---- design/arc_alarm_relay_controller.sv ----
// Alarm relay controller: eight alarms compared against a display value, driving eight relays.
// Assumes setpoints and settings are stable configuration inputs from the setup logic,
// the string strobe comes from the receiver on the same clock, and the acknowledge
// button is an asynchronous pin that is already debounced mechanically enough for sampling.
`timescale 1ns/1ns
module arc_alarm_relay_controller
    import arc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic signed [VAL_W-1:0] i_first_channel_value,
    input wire logic signed [VAL_W-1:0] i_wind_direction_value,
    input wire logic signed [VAL_W-1:0] i_wind_speed_value,
    input wire logic i_marine_mode,
    input wire logic i_extra_relays_fitted,
    input wire logic i_string_received,
    input wire logic [DLY_W-1:0] i_display_silence_period,
    input wire logic i_ack_button,
    input wire logic [NUM_ALARMS*VAL_W-1:0] i_over_limit,
    input wire logic [NUM_ALARMS-1:0] i_over_limit_enable,
    input wire logic [NUM_ALARMS*VAL_W-1:0] i_under_limit,
    input wire logic [NUM_ALARMS-1:0] i_under_limit_enable,
    input wire logic [NUM_ALARMS*VAL_W-1:0] i_deadband,
    input wire logic [NUM_ALARMS*DLY_W-1:0] i_assert_delay,
    input wire logic [NUM_ALARMS*DLY_W-1:0] i_release_delay,
    input wire logic [NUM_ALARMS*NUM_ALARMS-1:0] i_relay_allocation,
    input wire logic [NUM_ALARMS*FOLLOW_W-1:0] i_follow_mode_select,
    input wire logic [NUM_ALARMS*SRC_W-1:0] i_compare_source_select,
    input wire logic [NUM_ALARMS-1:0] i_hold_mode,
    input wire logic [NUM_ALARMS-1:0] i_timeout_enable,
    output logic [NUM_ALARMS-1:0] o_relay,
    output logic [NUM_ALARMS-1:0] o_alarm_active,
    output logic [NUM_ALARMS-1:0] o_annunciator,
    output logic o_stream_timeout
);

    // Widens a signed value so that a sum of two never wraps.
    function automatic logic signed [CMP_W-1:0] widen(input logic signed [VAL_W-1:0] v);
        widen = CMP_W'(v);
    endfunction : widen

    // Saturating tick counter step; no delay counts beyond the largest programmable one.
    function automatic logic [DLY_W-1:0] step_sat(input logic [DLY_W-1:0] c);
        step_sat = (c == DELAY_MAX_TICKS) ? c : c + 17'h00001;
    endfunction : step_sat

    // 0.1 s tick prescaler. One prescaler serves every delay, which costs up to one tick
    // of phase error per delay but saves a wide counter for each alarm.
    logic [PRESCALE_W-1:0] prescale_reg;
    logic tick_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            prescale_reg <= '0;
            tick_reg <= 1'b0;
        end else if (prescale_reg == PRESCALE_W'(TICK_CYCLES_P - 1)) begin
            prescale_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            prescale_reg <= prescale_reg + 25'h0000001;
            tick_reg <= 1'b0;
        end
    end

    // Flash phase shared by all annunciators so that they blink together.
    logic [FLASH_W-1:0] flash_phase_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            flash_phase_reg <= '0;
        end else if (tick_reg) begin
            flash_phase_reg <= (flash_phase_reg == FLASH_PERIOD - 4'h1) ? 4'h0
                             : flash_phase_reg + 4'h1;
        end
    end

    // Acknowledge button: three stages, a change counts once stages two and three agree.
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_s3_reg;
    logic ack_level_reg;
    logic ack_press;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            ack_s3_reg <= 1'b0;
            ack_level_reg <= 1'b0;
        end else begin
            ack_s1_reg <= i_ack_button;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
            if (ack_s2_reg == ack_s3_reg) begin
                ack_level_reg <= ack_s3_reg;
            end
        end
    end

    // Only the rising edge of the filtered level counts, so a held button acknowledges once.
    assign ack_press = (ack_s2_reg == ack_s3_reg) && ack_s3_reg && !ack_level_reg;

    // Serial stream silence watch. A string arriving on a tick restarts the count.
    // The count saturates, so a very long silence never wraps back below the period.
    logic [DLY_W-1:0] silence_cnt_reg;
    logic timeout_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            silence_cnt_reg <= '0;
            timeout_reg <= 1'b0;
        end else if (i_string_received) begin
            silence_cnt_reg <= '0;
            timeout_reg <= 1'b0;
        end else begin
            if (tick_reg) begin
                silence_cnt_reg <= step_sat(silence_cnt_reg);
            end
            timeout_reg <= (silence_cnt_reg > i_display_silence_period);
        end
    end

    assign o_stream_timeout = timeout_reg;

    // Per-alarm settings unpacked into arrays.
    logic signed [VAL_W-1:0] over_sp [NUM_ALARMS];
    logic signed [VAL_W-1:0] under_sp [NUM_ALARMS];
    logic signed [VAL_W-1:0] band [NUM_ALARMS];
    logic [DLY_W-1:0] trip_dly [NUM_ALARMS];
    logic [DLY_W-1:0] rel_dly [NUM_ALARMS];
    logic [FOLLOW_W-1:0] follow [NUM_ALARMS];
    logic [SRC_W-1:0] src_sel [NUM_ALARMS];

    always_comb begin
        for (int i = 0; i < NUM_ALARMS; i++) begin
            over_sp[i] = i_over_limit[i*VAL_W +: VAL_W];
            under_sp[i] = i_under_limit[i*VAL_W +: VAL_W];
            band[i] = i_deadband[i*VAL_W +: VAL_W];
            trip_dly[i] = i_assert_delay[i*DLY_W +: DLY_W];
            rel_dly[i] = i_release_delay[i*DLY_W +: DLY_W];
            follow[i] = i_follow_mode_select[i*FOLLOW_W +: FOLLOW_W];
            src_sel[i] = i_compare_source_select[i*SRC_W +: SRC_W];
        end
    end

    // Compared value per alarm. Wind sources fall back to the first channel outside marine mode.
    logic [SRC_W-1:0] eff_src [NUM_ALARMS];
    logic signed [CMP_W-1:0] cmp_val [NUM_ALARMS];

    always_comb begin
        for (int i = 0; i < NUM_ALARMS; i++) begin
            eff_src[i] = i_marine_mode ? src_sel[i] : ARC_SRC_FIRST_CHANNEL;
            if (eff_src[i] == ARC_SRC_WIND_DIR) begin
                cmp_val[i] = widen(i_wind_direction_value);
            end else if (eff_src[i] == ARC_SRC_WIND_SPEED) begin
                cmp_val[i] = widen(i_wind_speed_value);
            end else begin
                cmp_val[i] = widen(i_first_channel_value);
            end
        end
    end

    // Effective thresholds. Computed in ascending order so a trailed alarm that
    // itself trails is already resolved when a higher alarm reads it.
    // Sums are two bits wider than a value; offsets chained through many alarms must stay in range.
    logic signed [CMP_W-1:0] hi_th [NUM_ALARMS];
    logic signed [CMP_W-1:0] low_th [NUM_ALARMS];
    logic hi_en [NUM_ALARMS];
    logic low_en [NUM_ALARMS];
    logic trailing [NUM_ALARMS];
    int unsigned lead;

    always_comb begin
        lead = 0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            hi_th[i] = widen(over_sp[i]);
            low_th[i] = widen(under_sp[i]);
            hi_en[i] = i_over_limit_enable[i];
            low_en[i] = i_under_limit_enable[i];
            trailing[i] = 1'b0;
            // Follow code k means trail relay k, which is alarm index k-1.
            if (i_extra_relays_fitted && follow[i] != FOLLOW_OWN
                && int'(follow[i]) <= i) begin
                lead = int'(follow[i]) - 1;
                trailing[i] = (eff_src[i] == eff_src[lead]);
            end
            if (trailing[i]) begin
                hi_th[i] = hi_th[lead] + widen(over_sp[i]);
                low_th[i] = low_th[lead] + widen(under_sp[i]);
                hi_en[i] = i_over_limit_enable[i] && hi_en[lead];
                low_en[i] = i_under_limit_enable[i] && low_en[lead];
            end
        end
    end

    // Alarm state machine per alarm.
    // A hold mode alarm parks in the releasing state until it is acknowledged.
    arc_state_t state_reg [NUM_ALARMS];
    logic [DLY_W-1:0] trip_cnt_reg [NUM_ALARMS];
    logic [DLY_W-1:0] rel_cnt_reg [NUM_ALARMS];
    logic [NUM_ALARMS-1:0] acked_reg;
    logic [NUM_ALARMS-1:0] cond;
    logic [NUM_ALARMS-1:0] held;

    // Deadband applies only while the alarm is already on.
    always_comb begin
        for (int i = 0; i < NUM_ALARMS; i++) begin
            held[i] = (state_reg[i] == ARC_ACTIVE) || (state_reg[i] == ARC_RELEASING);
            cond[i] = 1'b0;
            if (hi_en[i]) begin
                if (held[i]) begin
                    cond[i] = cond[i] || (cmp_val[i] >= hi_th[i] - widen(band[i]));
                end else begin
                    cond[i] = cond[i] || (cmp_val[i] >= hi_th[i]);
                end
            end
            if (low_en[i]) begin
                if (held[i]) begin
                    cond[i] = cond[i] || (cmp_val[i] <= low_th[i] + widen(band[i]));
                end else begin
                    cond[i] = cond[i] || (cmp_val[i] <= low_th[i]);
                end
            end
            cond[i] = cond[i] || (i_timeout_enable[i] && timeout_reg);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                state_reg[i] <= ARC_IDLE;
                trip_cnt_reg[i] <= DELAY_DEFAULT_TICKS;
                rel_cnt_reg[i] <= DELAY_DEFAULT_TICKS;
            end
        end else begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                unique case (state_reg[i])
                    ARC_IDLE: begin
                        trip_cnt_reg[i] <= DELAY_DEFAULT_TICKS;
                        if (cond[i]) begin
                            state_reg[i] <= ARC_ARMING;
                        end
                    end
                    ARC_ARMING: begin
                        if (!cond[i]) begin
                            state_reg[i] <= ARC_IDLE;
                        end else if (trip_cnt_reg[i] >= trip_dly[i]) begin
                            state_reg[i] <= ARC_ACTIVE;
                            rel_cnt_reg[i] <= DELAY_DEFAULT_TICKS;
                        end else if (tick_reg) begin
                            trip_cnt_reg[i] <= step_sat(trip_cnt_reg[i]);
                        end
                    end
                    ARC_ACTIVE: begin
                        rel_cnt_reg[i] <= DELAY_DEFAULT_TICKS;
                        if (!cond[i]) begin
                            state_reg[i] <= ARC_RELEASING;
                        end
                    end
                    ARC_RELEASING: begin
                        if (cond[i]) begin
                            state_reg[i] <= ARC_ACTIVE;
                        end else if (rel_cnt_reg[i] >= rel_dly[i]) begin
                            // A held alarm waits here until acknowledged.
                            if (!i_hold_mode[i] || acked_reg[i]) begin
                                state_reg[i] <= ARC_IDLE;
                            end
                        end else if (tick_reg) begin
                            rel_cnt_reg[i] <= step_sat(rel_cnt_reg[i]);
                        end
                    end
                endcase
            end
        end
    end

    // Acknowledge memory. Entering alarm clears it; a press while on sets it.
    // Arming has priority so a press in the entering cycle is not applied to the new alarm.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            acked_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                if (state_reg[i] == ARC_ARMING || state_reg[i] == ARC_IDLE) begin
                    acked_reg[i] <= 1'b0;
                end else if (ack_press) begin
                    acked_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Relay and annunciator outputs.
    // They are registered one cycle behind the state so the relay pins never see a glitch.
    logic [NUM_ALARMS-1:0] relay_next;
    logic [NUM_ALARMS-1:0] annun_next;
    logic fast_on;
    logic slow_on;

    assign fast_on = (flash_phase_reg < FAST_ON_TICKS);
    assign slow_on = (flash_phase_reg < SLOW_ON_TICKS);

    always_comb begin
        relay_next = '0;
        annun_next = '0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            if (held[i]) begin
                relay_next = relay_next | i_relay_allocation[i*NUM_ALARMS +: NUM_ALARMS];
                if (!i_hold_mode[i] || acked_reg[i]) begin
                    annun_next[i] = 1'b1;
                end else if (state_reg[i] == ARC_ACTIVE) begin
                    annun_next[i] = fast_on;
                end else begin
                    annun_next[i] = slow_on;
                end
            end
        end
    end

    logic [NUM_ALARMS-1:0] relay_reg;
    logic [NUM_ALARMS-1:0] active_reg;
    logic [NUM_ALARMS-1:0] annun_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            relay_reg <= '0;
            active_reg <= '0;
            annun_reg <= '0;
        end else begin
            relay_reg <= relay_next;
            active_reg <= held;
            annun_reg <= annun_next;
        end
    end

    assign o_relay = relay_reg;
    assign o_alarm_active = active_reg;
    assign o_annunciator = annun_reg;

endmodule : arc_alarm_relay_controller

// ---- design/arc_pkg.sv ----
// Constants, encodings and timing figures shared by the alarm relay controller.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
package arc_pkg;
    localparam int NUM_ALARMS = 8;
    localparam int VAL_W = 32;
    localparam int CMP_W = VAL_W + 2;
    localparam int DLY_W = 17;
    localparam int FOLLOW_W = 3;
    localparam int SRC_W = 2;
    localparam int FLASH_W = 4;
    // Delay figures are held in 0.1 s ticks; 5000.0 s is 50000 ticks.
    localparam logic [DLY_W-1:0] DELAY_MAX_TICKS = 17'h0c350;
    localparam logic [DLY_W-1:0] DELAY_DEFAULT_TICKS = 17'h00000;
    localparam int TICK_TIME_NS = 100000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int PRESCALE_W = 25;
    // Annunciator patterns in ticks: fast flash 0.5 s on, 0.5 s off; slow 0.2 s on, 0.8 s off.
    localparam logic [FLASH_W-1:0] FLASH_PERIOD = 4'ha;
    localparam logic [FLASH_W-1:0] FAST_ON_TICKS = 4'h5;
    localparam logic [FLASH_W-1:0] SLOW_ON_TICKS = 4'h2;
    localparam logic [FOLLOW_W-1:0] FOLLOW_OWN = 3'h0;
    typedef enum logic [SRC_W-1:0] {
        ARC_SRC_FIRST_CHANNEL = 2'h0,
        ARC_SRC_WIND_DIR = 2'h1,
        ARC_SRC_WIND_SPEED = 2'h2
    } arc_src_t;
    typedef enum logic [1:0] {
        ARC_IDLE = 2'h0,
        ARC_ARMING = 2'h1,
        ARC_ACTIVE = 2'h3,
        ARC_RELEASING = 2'h2
    } arc_state_t;
endpackage : arc_pkg

// ---- dv/arc_alarm_relay_controller_assertions.sv ----
// Checker for the alarm relay controller, attached to its top module by bind.
// Assumes alarm 0 always compares the first channel and never uses the stream timeout.
`timescale 1ns/1ns
module arc_checker
    import arc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic signed [VAL_W-1:0] i_first_channel_value,
    input wire logic i_string_received,
    input wire logic [DLY_W-1:0] i_display_silence_period,
    input wire logic i_ack_button,
    input wire logic [NUM_ALARMS*VAL_W-1:0] i_over_limit,
    input wire logic [NUM_ALARMS-1:0] i_over_limit_enable,
    input wire logic [NUM_ALARMS*VAL_W-1:0] i_under_limit,
    input wire logic [NUM_ALARMS-1:0] i_under_limit_enable,
    input wire logic [NUM_ALARMS*DLY_W-1:0] i_assert_delay,
    input wire logic [NUM_ALARMS*NUM_ALARMS-1:0] i_relay_allocation,
    input wire logic [NUM_ALARMS-1:0] i_hold_mode,
    input wire logic [NUM_ALARMS-1:0] o_relay,
    input wire logic [NUM_ALARMS-1:0] o_alarm_active,
    input wire logic [NUM_ALARMS-1:0] o_annunciator,
    input wire logic o_stream_timeout
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic hi0, low0, ack_seen_reg;
    logic [NUM_ALARMS-1:0] relay_exp;
    int run0, need0, quiet, quiet_max;
    always_comb begin
        hi0 = i_over_limit_enable[0] && (i_first_channel_value >= $signed(i_over_limit[31:0]));
        low0 = i_under_limit_enable[0] && (i_first_channel_value <= $signed(i_under_limit[31:0]));
        need0 = (int'(i_assert_delay[DLY_W-1:0]) - 1) * TICK_CYCLES_P;
        quiet_max = int'(i_display_silence_period) * TICK_CYCLES_P;
        relay_exp = '0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            relay_exp = relay_exp | ({NUM_ALARMS{o_alarm_active[i]}}
                & i_relay_allocation[i*NUM_ALARMS+:NUM_ALARMS]);
        end
    end
    // Condition run length and string silence, counted in clock cycles.
    always_ff @(posedge i_ref_clk) begin
        run0 <= (i_rst || !(hi0 || low0)) ? 0 : run0 + 1;
    end
    always_ff @(posedge i_ref_clk) begin
        quiet <= (i_rst || i_string_received) ? 0 : quiet + 1;
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ack_seen_reg <= 1'b0;
        end else if (i_ack_button) begin
            ack_seen_reg <= 1'b1;
        end else if (!o_alarm_active[0]) begin
            ack_seen_reg <= 1'b0;
        end
    end
    sequence s_over0;
        (hi0 && i_assert_delay[DLY_W-1:0] == '0)[*3];
    endsequence
    sequence s_under0;
        (low0 && i_assert_delay[DLY_W-1:0] == '0)[*3];
    endsequence
    sequence s_clear;
        (o_relay == '0 && o_alarm_active == '0 && o_annunciator == '0 && !o_stream_timeout)[*2];
    endsequence
    a_reset_clears: assert property ($fell(i_rst) |-> s_clear)
        else $error("outputs not clear after reset");
    a_relay_alloc: assert property (o_relay == relay_exp)
        else $error("relay drive differs from allocation");
    a_over_rise: assert property (s_over0 |=> ##[0:1] o_alarm_active[0])
        else $error("over limit alarm late");
    a_under_rise: assert property (s_under0 |=> ##[0:1] o_alarm_active[0])
        else $error("under limit alarm late");
    a_trip_wait: assert property ($rose(o_alarm_active[0]) |-> run0 >= need0)
        else $error("alarm rose before its assert delay");
    a_hold_release: assert property ($fell(o_alarm_active[0]) && i_hold_mode[0] |-> ack_seen_reg)
        else $error("held alarm released without acknowledge");
    a_annun_alarm: assert property ((o_annunciator & ~o_alarm_active) == '0)
        else $error("annunciator lit without alarm");
    a_quiet_stream: assert property (quiet > 3 && quiet < quiet_max |-> !o_stream_timeout)
        else $error("stream timeout too early");
    a_string_clears: assert property (i_string_received |=> ##[0:2] !o_stream_timeout)
        else $error("stream timeout not cleared by string");
endmodule : arc_checker

// ---- dv/arc_alarm_relay_controller_bench.sv ----
// Self-checking bench for the alarm relay controller with a short tick of ten cycles.
// Assumes the checker and the panel model are compiled before this file.
`timescale 1ns/1ns
module arc_alarm_relay_controller_bench;
    import arc_pkg::*;
    logic clk, rst, marine, fitted, strb, press, ack, sto;
    logic signed [VAL_W-1:0] v, wd, ws;
    logic [DLY_W-1:0] sil;
    logic [NUM_ALARMS*VAL_W-1:0] ovl, unl, db;
    logic [NUM_ALARMS*DLY_W-1:0] ad, rd;
    logic [NUM_ALARMS*NUM_ALARMS-1:0] alloc;
    logic [NUM_ALARMS*FOLLOW_W-1:0] fol;
    logic [NUM_ALARMS*SRC_W-1:0] src;
    logic [NUM_ALARMS-1:0] ove, une, hold, toe, relay, act, ann;
    int err_count, compares, seed, r, on;
    int tv[8] = '{99, 100, 91, 90, 89, -50, -40, -39};
    int te[8] = '{0, 1, 1, 1, 0, 1, 1, 0};
    // Columns: fitted, marine, source, over offset, under offset, value, expected.
    int tt[9][7] = '{'{1, 0, 0, 50, -1000, 149, 0}, '{1, 0, 0, 50, -1000, 150, 1},
        '{1, 0, 0, -50, -1000, 50, 1}, '{1, 0, 0, -50, -1000, 49, 0},
        '{0, 0, 0, -50, -1000, 49, 1}, '{1, 1, 1, 50, -1000, 60, 1},
        '{1, 1, 2, 50, -1000, 60, 1}, '{1, 0, 0, 50, -10, -55, 0},
        '{1, 0, 0, 50, -10, -60, 1}};
    arc_alarm_relay_controller #(.TICK_CYCLES_P(10)) dut (
        .i_ref_clk(clk), .i_rst(rst), .i_first_channel_value(v),
        .i_wind_direction_value(wd), .i_wind_speed_value(ws), .i_marine_mode(marine),
        .i_extra_relays_fitted(fitted), .i_string_received(strb),
        .i_display_silence_period(sil), .i_ack_button(ack), .i_over_limit(ovl),
        .i_over_limit_enable(ove), .i_under_limit(unl), .i_under_limit_enable(une),
        .i_deadband(db), .i_assert_delay(ad), .i_release_delay(rd),
        .i_relay_allocation(alloc), .i_follow_mode_select(fol),
        .i_compare_source_select(src), .i_hold_mode(hold), .i_timeout_enable(toe),
        .o_relay(relay), .o_alarm_active(act), .o_annunciator(ann), .o_stream_timeout(sto));
    arc_panel_model u_panel (.i_ref_clk(clk), .i_press(press), .o_ack_button(ack));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic count_on(input int n);
        on = 0;
        repeat (n) begin
            @(posedge clk);
            if (ann[0] === 1'b1) on++;
        end
    endtask : count_on
    function automatic logic [7:0] f_relay(input logic [7:0] a, input logic [63:0] m);
        f_relay = 8'h00;
        for (int i = 0; i < 8; i++) f_relay = f_relay | ({8{a[i]}} & m[i*8+:8]);
    endfunction : f_relay
    task automatic wrap_up();
        if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        seed = 32'h7cf067fc;
        err_count = 0;
        compares = 0;
        {rst, marine, fitted, strb, press} = 5'h10;
        {v, wd, ws, ad, rd, fol, src, hold, toe} = '0;
        {ovl, unl, db, alloc} = '0;
        sil = 17'h00002;
        ove = 8'h03;
        une = 8'h03;
        ovl[31:0] = 32'h00000064;
        unl[31:0] = 32'hffffffce;
        db[31:0] = 32'h0000000a;
        alloc[7:0] = 8'h05;
        cyc(8);
        rst <= 1'b0;
        cyc(2);
        chk("outputs", {relay, act, ann, sto}, '0);
        for (int k = 0; k < 8; k++) begin
            v <= tv[k];
            cyc(8);
            chk("alarm0", act[0], te[k]);
            chk("relays", relay, f_relay({7'h0, te[k][0]}, alloc));
        end
        r = $random(seed);
        v <= 100 + (r & 32'h3ff);
        cyc(8);
        chk("alarm0", act[0], 1);
        v <= 0;
        cyc(8);
        ad[16:0] <= 17'h00003;
        v <= 200;
        cyc(20);
        v <= 0;
        cyc(1);
        v <= 200;
        cyc(22);
        chk("trip", act[0], 0);
        cyc(25);
        chk("trip", act[0], 1);
        rd[16:0] <= 17'h00003;
        v <= 0;
        cyc(20);
        chk("release", act[0], 1);
        v <= -60;
        cyc(2);
        v <= 0;
        cyc(22);
        chk("release", act[0], 1);
        cyc(25);
        chk("release", act[0], 0);
        {ad, rd, db} <= '0;
        fol[5:3] <= 3'h1;
        for (int k = 0; k < 9; k++) begin
            fitted <= tt[k][0][0];
            marine <= tt[k][1][0];
            src[3:2] <= tt[k][2][1:0];
            ovl[63:32] <= tt[k][3];
            unl[63:32] <= tt[k][4];
            v <= (tt[k][2] == 0) ? tt[k][5] : 0;
            wd <= tt[k][5];
            ws <= tt[k][5];
            cyc(8);
            chk("alarm1", act[1], tt[k][6]);
        end
        fol[5:3] <= 3'h2;
        v <= -20;
        cyc(8);
        chk("alarm1", act[1], 1);
        {fitted, marine, fol, src, v} <= '0;
        cyc(8);
        hold[0] <= 1'b1;
        v <= 200;
        cyc(8);
        count_on(100);
        chk("flash", on, 50);
        v <= 0;
        cyc(20);
        count_on(100);
        chk("flash", on, 20);
        chk("held", act[0], 1);
        press <= 1'b1;
        cyc(1);
        press <= 1'b0;
        cyc(40);
        chk("acked", {act[0], relay}, 0);
        v <= 200;
        cyc(8);
        press <= 1'b1;
        cyc(1);
        press <= 1'b0;
        cyc(40);
        count_on(20);
        chk("steady", on, 20);
        v <= 0;
        cyc(8);
        chk("acked", act[0], 0);
        hold <= '0;
        toe[2] <= 1'b1;
        strb <= 1'b1;
        cyc(1);
        strb <= 1'b0;
        cyc(8);
        chk("timeout", {sto, act[2]}, 0);
        cyc(40);
        chk("timeout", {sto, act[2]}, 3);
        for (int k = 0; k < 30; k++) begin
            strb <= 1'b1;
            cyc(1);
            strb <= 1'b0;
            r = $random(seed);
            cyc(1 + (r & 32'h7));
        end
        chk("timeout", {sto, act[2]}, 0);
        ove[2] <= 1'b1;
        cyc(8);
        chk("limit", act[2], 1);
        wrap_up();
    end
endmodule : arc_alarm_relay_controller_bench
bind arc_alarm_relay_controller arc_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_first_channel_value(i_first_channel_value),
    .i_string_received(i_string_received), .i_display_silence_period(i_display_silence_period),
    .i_ack_button(i_ack_button), .i_over_limit(i_over_limit),
    .i_over_limit_enable(i_over_limit_enable), .i_under_limit(i_under_limit),
    .i_under_limit_enable(i_under_limit_enable), .i_assert_delay(i_assert_delay),
    .i_relay_allocation(i_relay_allocation), .i_hold_mode(i_hold_mode), .o_relay(o_relay),
    .o_alarm_active(o_alarm_active), .o_annunciator(o_annunciator),
    .o_stream_timeout(o_stream_timeout));

// ---- dv/arc_panel_model.sv ----
// Front panel model: the acknowledge push button, pulled low when not pressed.
// Assumes the bench asks for a press by a one-cycle request on the system clock.
`timescale 1ns/1ns
module arc_panel_model (
    input wire logic i_ref_clk,
    input wire logic i_press,
    output logic o_ack_button
);
    // A press is held well past the three-stage synchroniser so it is never missed.
    int hold_cnt = 0;
    always @(posedge i_ref_clk) begin
        if (i_press) begin
            hold_cnt <= 24;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end
    assign o_ack_button = (hold_cnt > 0);
endmodule : arc_panel_model
